// ### pkg/sbs_params.svh
/*
 * Constants for the synchronous burst memory control block: field widths,
 * burst counter size, sleep timing, buffer depth and reset values.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef SBS_PARAMS_SVH
`define SBS_PARAMS_SVH


// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define SBS_LANES 4
`define SBS_LANE_W 9
`define SBS_ADDR_W 6
`define SBS_CNT_W 2
`define SBS_FIFO_DEPTH 4

// ---------------------------------------------------------------
// Timing and reset values
// ---------------------------------------------------------------
`define SBS_SLEEP_CYCLES 2
`define SBS_CNT_RESET 2'h0
`define SBS_CNT_LAST 2'h3
`define SBS_OE_N_RESET 1'b1

`endif

// ### pkg/sbs_pkg.sv
/*
 * Types for the synchronous burst memory control block.
 * Assumes the constants header is on the include path.
 */
`include "sbs_params.svh"

package sbs_pkg;

    typedef enum logic [1:0] {OP_DESEL, OP_READ, OP_WRITE, OP_ABORT} op_t;

    // Synchronous control pins sampled at each accepted rising edge
    typedef struct packed {
        logic burst_step_select;
        logic write_select_n;
        logic [`SBS_LANES-1:0] byte_lane_strobes_n;
        logic chip_select_a_n;
        logic chip_select_b;
        logic chip_select_c_n;
    } ctrl_t;

    typedef struct packed {
        op_t op;
        logic [`SBS_ADDR_W-1:0] addr;
        logic [`SBS_LANES-1:0] lanes_n;
    } stage_t;

    typedef struct packed {
        logic [`SBS_ADDR_W-1:0] addr;
        logic [`SBS_LANES-1:0] lanes_n;
        logic [`SBS_LANES*`SBS_LANE_W-1:0] data;
    } wr_word_t;

endpackage : sbs_pkg

// ### verilog/sync_burst_sram_control.sv
/*
 * Command and control logic of a synchronous burst memory with no bus
 * turnaround: command decode, clock-edge stalls, burst counter, flow-through
 * or pipelined data path, output drive control and sleep handling, plus the
 * write buffer that sits between the data pins and the storage array.
 * Assumes a single clock and control pins synchronous to it, except sleep.
 */
`timescale 1ns/1ps
`include "sbs_params.svh"

module sbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `SBS_FIFO_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] slot_q [0:DEPTH-1];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
        ptr_next = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : ptr_next

    assign in_ready_o = (count_q != CW'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign out_data_o = slot_q[rd_ptr_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            slot_q[wr_ptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= ptr_next(wr_ptr_q);
            end
            if (pop) begin
                rd_ptr_q <= ptr_next(rd_ptr_q);
            end
            if (push && !pop) begin
                count_q <= CW'(count_q + 1'b1);
            end else if (pop && !push) begin
                count_q <= CW'(count_q - 1'b1);
            end
        end
    end
endmodule : sbs_fifo

module sync_burst_sram_control
    import sbs_pkg::*;
#(
    parameter int ADDR_W = `SBS_ADDR_W,
    parameter int FIFO_DEPTH = `SBS_FIFO_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clock_gate_n_i,
    input wire ctrl_t ctrl_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [`SBS_LANES*`SBS_LANE_W-1:0] dq_i,
    input wire logic output_enable_n_i,
    input wire logic sleep_request_i,
    input wire logic burst_order_select_n_i,
    input wire logic output_register_select_n_i,
    output logic [`SBS_LANES*`SBS_LANE_W-1:0] dq_o,
    output logic dq_oe_n_o,
    output logic power_down_o,
    output logic asleep_o,
    output logic write_buffer_ready_o
);
    localparam int DW = `SBS_LANES * `SBS_LANE_W;
    localparam int WW = ADDR_W + `SBS_LANES + DW;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic [DW-1:0] mem_q [0:(1<<ADDR_W)-1];
    logic sleep_meta_q;
    logic sleep_sync_q;
    op_t burst_op_q;
    logic [`SBS_CNT_W-1:0] base_q;
    logic [`SBS_CNT_W-1:0] cnt_q;
    logic [ADDR_W-1:0] upper_q;
    stage_t s1_q;
    stage_t s2_q;
    logic drive_q;
    logic [DW-1:0] dout_q;
    logic oe_n_q;
    logic power_down_q;
    logic buf_ready_q;

    stage_t cur;
    logic [`SBS_CNT_W-1:0] cnt_d;
    logic selected;
    logic go;
    logic pipelined;
    logic rd_fetch;
    logic [ADDR_W-1:0] rd_addr;
    logic drive_d;
    stage_t wr_src;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    wr_word_t fifo_out;
    wr_word_t fifo_in;

    function automatic logic [`SBS_CNT_W-1:0] burst_low(
        input logic [`SBS_CNT_W-1:0] base,
        input logic [`SBS_CNT_W-1:0] cnt,
        input logic interleave
    );
        burst_low = interleave ? (base ^ cnt) : `SBS_CNT_W'(base + cnt);
    endfunction : burst_low

    // ---------------------------------------------------------------
    // Sleep request synchroniser
    // ---------------------------------------------------------------
    // Two stages give both the entry and the wake-up delay.
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sleep_meta_q <= 1'b0;
            sleep_sync_q <= 1'b0;
        end else begin
            sleep_meta_q <= sleep_request_i;
            sleep_sync_q <= sleep_meta_q;
        end
    end

    // ---------------------------------------------------------------
    // Command decode
    // ---------------------------------------------------------------
    assign pipelined = output_register_select_n_i;
    assign selected = !ctrl_i.chip_select_a_n && ctrl_i.chip_select_b
                      && !ctrl_i.chip_select_c_n;
    // A full write buffer stalls the edge just as the clock gate does.
    assign go = !clock_gate_n_i && !sleep_sync_q && fifo_in_ready;

    always_comb begin
        cur = '0;
        cnt_d = `SBS_CNT_RESET;
        cur.lanes_n = ctrl_i.byte_lane_strobes_n;
        if (!ctrl_i.burst_step_select) begin
            cur.addr = addr_i;
            if (!selected) begin
                cur.op = OP_DESEL;
            end else if (ctrl_i.write_select_n) begin
                cur.op = OP_READ;
            end else if (&ctrl_i.byte_lane_strobes_n) begin
                cur.op = OP_ABORT;
            end else begin
                cur.op = OP_WRITE;
            end
        end else begin
            cnt_d = `SBS_CNT_W'(cnt_q + 1'b1);
            cur.addr = {upper_q[ADDR_W-1:`SBS_CNT_W],
                        burst_low(base_q, cnt_d, burst_order_select_n_i)};
            if (burst_op_q == OP_DESEL) begin
                cur.op = OP_DESEL;
            end else if (burst_op_q == OP_READ) begin
                cur.op = OP_READ;
            end else if (&ctrl_i.byte_lane_strobes_n) begin
                cur.op = OP_ABORT;
            end else begin
                cur.op = OP_WRITE;
            end
        end
    end

    // ---------------------------------------------------------------
    // Burst counter and command stages
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            burst_op_q <= OP_DESEL;
            base_q <= `SBS_CNT_RESET;
            cnt_q <= `SBS_CNT_RESET;
            upper_q <= '0;
        end else if (sleep_sync_q) begin
            burst_op_q <= OP_DESEL;
        end else if (go) begin
            cnt_q <= cnt_d;
            if (!ctrl_i.burst_step_select) begin
                base_q <= addr_i[`SBS_CNT_W-1:0];
                upper_q <= addr_i;
                burst_op_q <= (cur.op == OP_ABORT) ? OP_WRITE : cur.op;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s1_q <= '0;
            s2_q <= '0;
        end else if (sleep_sync_q) begin
            s1_q.op <= OP_DESEL;
            s2_q.op <= OP_DESEL;
        end else if (go) begin
            s1_q <= cur;
            s2_q <= s1_q;
        end
    end

    // ---------------------------------------------------------------
    // Read path and output drive
    // ---------------------------------------------------------------
    assign rd_addr = pipelined ? s1_q.addr : cur.addr;
    assign rd_fetch = go && (pipelined ? (s1_q.op == OP_READ) : (cur.op == OP_READ));
    // A stall holds the drive state: pipelined read data stays on the bus.
    assign drive_d = sleep_sync_q ? 1'b0 : (go ? rd_fetch : drive_q);

    always_ff @(posedge sys_clk_i) begin
        if (rd_fetch) begin
            dout_q <= mem_q[rd_addr];
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            drive_q <= 1'b0;
            oe_n_q <= `SBS_OE_N_RESET;
        end else begin
            drive_q <= drive_d;
            oe_n_q <= !(drive_d && !output_enable_n_i);
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            power_down_q <= 1'b1;
            buf_ready_q <= 1'b0;
        end else begin
            buf_ready_q <= fifo_in_ready;
            if (sleep_sync_q) begin
                power_down_q <= 1'b1;
            end else if (go) begin
                power_down_q <= (cur.op == OP_DESEL);
            end
        end
    end

    // ---------------------------------------------------------------
    // Write path
    // ---------------------------------------------------------------
    // Late write: data is taken one or two accepted edges after the command.
    assign wr_src = pipelined ? s2_q : s1_q;
    assign fifo_in.addr = wr_src.addr;
    assign fifo_in.lanes_n = wr_src.lanes_n;
    assign fifo_in.data = dq_i;
    // The array has one port; a read fetch holds the buffer back.
    assign fifo_out_ready = !rd_fetch;

    sbs_fifo #(
        .WIDTH(WW),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .in_valid_i(go && (wr_src.op == OP_WRITE)),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out)
    );

    // Limitation: a read of a word still in the buffer returns the old value.
    always_ff @(posedge sys_clk_i) begin
        if (fifo_out_valid && fifo_out_ready) begin
            for (int l = 0; l < `SBS_LANES; l++) begin
                if (!fifo_out.lanes_n[l]) begin
                    mem_q[fifo_out.addr][l*`SBS_LANE_W +: `SBS_LANE_W]
                        <= fifo_out.data[l*`SBS_LANE_W +: `SBS_LANE_W];
                end
            end
        end
    end

    assign dq_o = dout_q;
    assign dq_oe_n_o = oe_n_q;
    assign power_down_o = power_down_q;
    assign asleep_o = sleep_sync_q;
    assign write_buffer_ready_o = buf_ready_q;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_ft_read_cmd;
        go && !pipelined && (cur.op == OP_READ) && !output_enable_n_i;
    endsequence
    sequence s_pipe_read_cmd;
        go && pipelined && (cur.op == OP_READ);
    endsequence
    sequence s_pipe_read_data;
        go && pipelined && !output_enable_n_i;
    endsequence

    a_ft_read_drive: assert property (s_ft_read_cmd |=> !dq_oe_n_o)
        else $error("flow-through read not driven next cycle");
    a_pipe_read_drive: assert property (s_pipe_read_cmd ##1 s_pipe_read_data |=> !dq_oe_n_o)
        else $error("pipelined read not driven after second edge");
    a_dummy_read_off: assert property (output_enable_n_i |=> dq_oe_n_o)
        else $error("bus driven with output drive enable high");
    a_ft_write_off: assert property (go && !pipelined && cur.op == OP_WRITE |=> dq_oe_n_o)
        else $error("bus driven during write cycle");
    a_sleep_bus_off: assert property (sleep_sync_q |=> dq_oe_n_o && power_down_o)
        else $error("outputs active while asleep");
    a_sleep_entry: assert property (sleep_request_i [*2] |=> asleep_o)
        else $error("sleep not entered after two cycles");
    a_sleep_exit: assert property (!sleep_request_i [*2] |=> !asleep_o)
        else $error("sleep not left after two cycles");
    a_stall_hold: assert property (clock_gate_n_i |=> $stable(cnt_q) && $stable(s1_q))
        else $error("state moved on an ignored edge");
    a_burst_wrap: assert property (go && ctrl_i.burst_step_select && cnt_q == `SBS_CNT_LAST
                                   |=> cnt_q == `SBS_CNT_RESET)
        else $error("burst counter failed to wrap");
    a_counter_load: assert property (go && !ctrl_i.burst_step_select
        |=> cnt_q == `SBS_CNT_RESET && base_q == $past(addr_i[`SBS_CNT_W-1:0]))
        else $error("burst counter not loaded");
    a_deselect_power: assert property (go && !ctrl_i.burst_step_select && !selected
                                       |=> power_down_o && s1_q.op == OP_DESEL)
        else $error("deselect not taken");
    a_abort_no_write: assert property (go && !ctrl_i.burst_step_select && selected
        && !ctrl_i.write_select_n && &ctrl_i.byte_lane_strobes_n |=> s1_q.op == OP_ABORT)
        else $error("write with no strobes not treated as no-operation");
    a_upper_hold: assert property (go && ctrl_i.burst_step_select
        |=> s1_q.addr[ADDR_W-1:`SBS_CNT_W] == $past(upper_q[ADDR_W-1:`SBS_CNT_W]))
        else $error("upper address changed during burst");
    a_powerup_off: assert property ($fell(reset_i) |-> dq_oe_n_o)
        else $error("bus driven at power-up");

endmodule : sync_burst_sram_control

// ### bench/host_model.sv
/*
 * Controller-side model: drives one command slot per clock edge onto the
 * control, address, write data, output enable and sleep pins.
 * Assumes the bench keeps expectations and calls slot once per edge.
 */
`timescale 1ns/1ps
`include "sbs_params.svh"
module host_model
    import sbs_pkg::*;
(
    input wire logic sys_clk_i,
    output logic clock_gate_n_o,
    output ctrl_t ctrl_o,
    output logic [`SBS_ADDR_W-1:0] addr_o,
    output logic [`SBS_LANES*`SBS_LANE_W-1:0] dq_o,
    output logic output_enable_n_o,
    output logic sleep_request_o
);
    // Accepted edges as the controller counts them; the bench resyncs it
    int acc_d = 0;

    // ----------------------------------------
    // Idle pins from time zero
    // ----------------------------------------
    initial begin
        clock_gate_n_o = 1'b0;
        ctrl_o = 9'h1e6;
        addr_o = '0;
        dq_o = '0;
        output_enable_n_o = 1'b0;
        sleep_request_o = 1'b0;
    end

    // ----------------------------------------
    // One slot: change just after an edge, hold until the next
    // ----------------------------------------
    task automatic slot(input logic gate_n, input logic step, input logic wr_n,
        input logic [3:0] lanes_n, input logic [2:0] cs, input logic [5:0] a,
        input logic [`SBS_LANES*`SBS_LANE_W-1:0] d, input logic oe_n, input logic slp);
        @(posedge sys_clk_i);
        clock_gate_n_o <= gate_n;
        ctrl_o <= {step, wr_n, lanes_n, cs};
        addr_o <= a;
        dq_o <= d;
        output_enable_n_o <= oe_n;
        // Sleep only raised with the bus idle, only deselects on wake
        sleep_request_o <= slp;
        if (!gate_n) acc_d++;
    endtask : slot
endmodule : host_model

// ### bench/sync_burst_sram_control_tb.sv
/*
 * Self-checking bench: bursts through the controller model, a reference
 * array and a queue of expected data-pin states checked at each edge.
 * Assumes read data shows one accepted edge after the command in
 * flow-through mode and two in pipelined mode.
 */
`timescale 1ns/1ps
`include "sbs_params.svh"
module sync_burst_sram_control_tb
    import sbs_pkg::*;
;
    localparam int DW = `SBS_LANES*`SBS_LANE_W;
    typedef struct {int due; logic oe_n; logic [DW-1:0] d;} note_t;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic order_n = 1'b0;
    logic regsel_n = 1'b0;
    logic gate_n, oe_n, sleep_req, dq_oe_n, pd, asleep, wbr;
    ctrl_t ctrl;
    logic [`SBS_ADDR_W-1:0] addr;
    logic [DW-1:0] dq_w, dq_r;
    logic [DW-1:0] ref_mem [2**`SBS_ADDR_W];
    note_t notes[$];
    note_t cur;
    int seed = 85;
    int acc_m = 0;
    int bad_count = 0;
    int n_tests = 0;
    int lat = 1;
    logic [5:0] b;

    initial forever #20 sys_clk = ~sys_clk;

    host_model host_u (.sys_clk_i(sys_clk), .clock_gate_n_o(gate_n), .ctrl_o(ctrl),
        .addr_o(addr), .dq_o(dq_w), .output_enable_n_o(oe_n), .sleep_request_o(sleep_req));

    sync_burst_sram_control dut_u (.sys_clk_i(sys_clk), .reset_i(reset),
        .clock_gate_n_i(gate_n), .ctrl_i(ctrl), .addr_i(addr), .dq_i(dq_w),
        .output_enable_n_i(oe_n), .sleep_request_i(sleep_req),
        .burst_order_select_n_i(order_n), .output_register_select_n_i(regsel_n),
        .dq_o(dq_r), .dq_oe_n_o(dq_oe_n), .power_down_o(pd), .asleep_o(asleep),
        .write_buffer_ready_o(wbr));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [DW-1:0] rnd();
        return DW'({$random(seed), $random(seed)});
    endfunction : rnd

    function automatic logic [5:0] seq(input logic [5:0] base, input int i);
        logic [1:0] k;
        k = 2'(i);
        return {base[5:2], order_n ? base[1:0] ^ k : base[1:0] + k};
    endfunction : seq

    task automatic check(input string nm, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic conclude();
        if (bad_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude

    // The watcher looks just after an edge, so a result launched by edge n is due at n
    task automatic note(input logic o, input logic [DW-1:0] d);
        notes.push_back('{host_u.acc_d + lat - 1, o, d});
    endtask : note

    // Held deselect from the previous slot lands on the edge after this one
    task automatic resync();
        @(posedge sys_clk);
        #1;
        host_u.acc_d = acc_m + 1;
        check("power_down", DW'(pd), DW'(1'b1));
        check("buffer_ready", DW'(wbr), DW'(1'b1));
    endtask : resync

    task automatic desel(input int k, input logic [DW-1:0] d);
        logic [2:0] cs;
        cs = k % 3 == 0 ? 3'b110 : k % 3 == 1 ? 3'b000 : 3'b011;
        host_u.slot(1'b0, 1'b0, 1'(rnd()), 4'(rnd()), cs, 6'(rnd()), d, 1'b0, 1'b0);
        note(1'b1, '0);
    endtask : desel

    // Ignored edges carry a live write elsewhere, which must not land
    task automatic stall();
        repeat (2) host_u.slot(1'b1, 1'b0, 1'b0, 4'h0, 3'b010, 6'(rnd()), rnd(), 1'b0, 1'b0);
    endtask : stall

    // ----------------------------------------
    // Bursts
    // ----------------------------------------
    task automatic wr_burst(input logic [3:0] ln, input int st);
        logic [DW-1:0] wd [4];
        for (int i = 0; i < 4; i++) wd[i] = rnd();
        for (int j = 0; j < 4 + lat; j++) begin
            if (j == st) stall();
            if (j < 4) begin
                host_u.slot(1'b0, j > 0, j > 0 ? 1'(rnd()) : 1'b0, ln,
                    j > 0 ? 3'(rnd()) : 3'b010, j > 0 ? 6'(rnd()) : b,
                    j >= lat ? wd[j - lat] : rnd(), 1'b0, 1'b0);
                note(1'b1, '0);
            end else begin
                desel(j, wd[j - lat]);
            end
        end
        for (int i = 0; i < 4; i++) begin
            for (int l = 0; l < 4; l++) begin
                if (!ln[l]) ref_mem[seq(b, i)][9*l +: 9] = wd[i][9*l +: 9];
            end
        end
        for (int k = 0; k < 4; k++) desel(k, rnd());
    endtask : wr_burst

    task automatic rd_burst(input int n, input logic o, input int st);
        for (int i = 0; i < n; i++) begin
            if (i == st) stall();
            host_u.slot(1'b0, i > 0, i > 0 ? 1'(rnd()) : 1'b1, 4'hf,
                i > 0 ? 3'(rnd()) : 3'b010, i > 0 ? 6'(rnd()) : b, rnd(), o, 1'b0);
            note(o, ref_mem[seq(b, i)]);
        end
        // Pipelined data leaves on this edge, so the drive enable must still be o
        host_u.slot(1'b0, 1'b0, 1'b1, 4'hf, 3'b110, 6'(rnd()), rnd(), o, 1'b0);
        note(1'b1, '0);
    endtask : rd_burst

    // ----------------------------------------
    // Output watcher
    // ----------------------------------------
    always @(posedge sys_clk or posedge reset) begin
        if (reset) acc_m <= 0;
        else if (gate_n === 1'b0 && asleep === 1'b0) acc_m <= acc_m + 1;
    end

    always @(posedge sys_clk) begin
        #1;
        if (reset) begin
            notes.delete();
            cur = '{0, 1'b1, '0};
        end
        while (notes.size() > 0 && notes[0].due <= acc_m) cur = notes.pop_front();
        check("drive_n", DW'(dq_oe_n), DW'(cur.oe_n));
        if (cur.oe_n == 1'b0) check("data", dq_r, cur.d);
    end

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        for (int m = 0; m < 2; m++) begin
            reset <= 1'b1;
            order_n <= 1'(m);
            regsel_n <= 1'(m);
            lat = m + 1;
            repeat (3) @(posedge sys_clk);
            reset <= 1'b0;
            resync();
            host_u.slot(1'b0, 1'b1, 1'b1, 4'hf, 3'b010, 6'h00, rnd(), 1'b0, 1'b0);
            note(1'b1, '0);
            b = 6'(rnd());
            wr_burst(4'h0, 9);
            rd_burst(5, 1'b0, 9);
            wr_burst(4'b1110, 2);
            wr_burst(4'hf, 9);
            rd_burst(4, 1'b0, 2);
            rd_burst(4, 1'b1, 9);
        end
        host_u.slot(1'b0, 1'b0, 1'b1, 4'hf, 3'b110, b, rnd(), 1'b0, 1'b1);
        note(1'b1, '0);
        @(posedge sys_clk);
        #1;
        check("asleep", DW'(asleep), DW'(1'b0));
        @(posedge sys_clk);
        #1;
        check("asleep", DW'(asleep), DW'(1'b1));
        check("power_down", DW'(pd), DW'(1'b1));
        repeat (3) host_u.slot(1'b0, 1'b0, 1'b0, 4'h0, 3'b010, b, rnd(), 1'b0, 1'b1);
        host_u.slot(1'b0, 1'b0, 1'b1, 4'hf, 3'b110, b, rnd(), 1'b0, 1'b0);
        @(posedge sys_clk);
        #1;
        check("asleep", DW'(asleep), DW'(1'b1));
        @(posedge sys_clk);
        #1;
        check("asleep", DW'(asleep), DW'(1'b0));
        resync();
        desel(0, rnd());
        desel(1, rnd());
        rd_burst(4, 1'b0, 9);
        conclude();
    end

    // Whole run is about 125 edges; this margin only cuts a hang
    initial begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        conclude();
    end
endmodule : sync_burst_sram_control_tb
